// ---- hdl/mode_select_consts.svh ----
/*
 * constants for the serializer mode select block: register offsets, field
 * positions, reset values and encodings. assumes inclusion by bare name.
 */
`ifndef MODE_SELECT_CONSTS_SVH
`define MODE_SELECT_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define OFS_FEATURE_DISABLE 12'h000
`define OFS_STATUS 12'h004
`define OFS_PINS 12'h008

// ****************************************************************
// feature disable register fields
// ****************************************************************
`define FEAT_W 5
`define FEAT_EDH 0
`define FEAT_PID 1
`define FEAT_CSUM 2
`define FEAT_TRS 3
`define FEAT_REMAP 4
`define FEAT_DIS_RESET 5'h00
`define FEAT_ALL 5'h1f
`define FEAT_NONE 5'h00

// ****************************************************************
// status register fields
// ****************************************************************
`define ST_MODE_LSB 0
`define ST_WIDE 2
`define ST_SCRAMBLE 3
`define ST_ASI_ENC 4
`define ST_FEAT_LSB 8

// ****************************************************************
// pin register fields
// ****************************************************************
`define PIN_TRANSPORT 0
`define PIN_VIDEO 1
`define PIN_WIDTH 2
`define PIN_MASTER 3

// ****************************************************************
// bus constants
// ****************************************************************
`define ADDR_W 12
`define WORD_ZERO 32'h0000_0000

`endif

// ---- hdl/mode_select_pkg.sv ----
/*
 * types for the serializer mode select block.
 * assumes mode_select_consts.svh is on the include path.
 */
package mode_select_pkg;
  `include "mode_select_consts.svh"

  typedef enum logic [1:0] {
    MODE_PASS,
    MODE_VIDEO,
    MODE_TRANSPORT,
    MODE_CONFLICT
  } transport_mode_t;

  typedef struct packed {
    logic transport_mode_pin;
    logic video_path_enable_pin;
    logic bus_width_select;
    logic processing_master_enable;
  } ctrl_pins_t;

  typedef struct packed {
    transport_mode_t mode;
    logic wide_bus;
    logic scramble_en;
    logic asi_encode_en;
    logic [`FEAT_W-1:0] feature_en;
  } mode_ctrl_t;
endpackage

// ---- hdl/pin_sync.sv ----
/*
 * two-flop synchroniser for a group of static control pins.
 * assumes the pins are asynchronous to pclk and change slowly.
 */
`timescale 1ns/10ps
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input mode_select_pkg::ctrl_pins_t pins_in,
  output mode_select_pkg::ctrl_pins_t pins_out
);
  import mode_select_pkg::*;

  ctrl_pins_t meta_reg;
  ctrl_pins_t sync_reg;

  // ****************************************************************
  // two flip-flop stages
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
    end
  end

  assign pins_out = sync_reg;
endmodule

// ---- hdl/serializer_mode_select.sv ----
/*
 * serializer mode select: decodes static control pins into transport mode,
 * input bus width and processing feature enables; apb register access.
 * assumes an apb master on pclk and slowly changing asynchronous pins.
 */
// Notes on behaviour
// - transport high and video low selects asi mode: sync insert, 8b/10b
// - transport pin low means no asi encoding
// - width select applies in every mode except asi: video, pass-through and conflict
// - in asi mode width select is ignored
// - width high gives 20-bit words, low gives 10-bit words
// - master enable high enables the five processing features in video mode only
// - host keeps master high and sets disable bits to drop features
// - master enable low disables every feature regardless of register
// - video high and transport low selects video mode with scrambling
// - video pin low: no scrambling, no features
`timescale 1ns/10ps
`include "mode_select_consts.svh"
module serializer_mode_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input mode_select_pkg::ctrl_pins_t pins,
  output mode_select_pkg::mode_ctrl_t mode_ctrl
);
  import mode_select_pkg::*;

  ctrl_pins_t pins_sync;
  logic [`FEAT_W-1:0] feature_disable_reg;
  mode_ctrl_t ctrl_next;
  mode_ctrl_t ctrl_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic wr_en;
  logic rd_en;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins_in(pins),
    .pins_out(pins_sync)
  );

  // ****************************************************************
  // mode decode
  // ****************************************************************
  function automatic transport_mode_t decode_mode(input ctrl_pins_t p);
    unique case ({p.transport_mode_pin, p.video_path_enable_pin})
      2'b10: decode_mode = MODE_TRANSPORT;
      2'b01: decode_mode = MODE_VIDEO;
      2'b00: decode_mode = MODE_PASS;
      2'b11: decode_mode = MODE_CONFLICT;
    endcase
  endfunction

  always_comb begin
    ctrl_next.mode = decode_mode(pins_sync);
    // width only counts outside asi mode
    ctrl_next.wide_bus = (ctrl_next.mode != MODE_TRANSPORT) &&
                         pins_sync.bus_width_select;
    ctrl_next.scramble_en = (ctrl_next.mode == MODE_VIDEO);
    ctrl_next.asi_encode_en = (ctrl_next.mode == MODE_TRANSPORT);
    if (ctrl_next.mode == MODE_VIDEO && pins_sync.processing_master_enable) begin
      ctrl_next.feature_en = `FEAT_ALL & ~feature_disable_reg;
    end else begin
      ctrl_next.feature_en = `FEAT_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign mode_ctrl = ctrl_reg;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `OFS_FEATURE_DISABLE) || (a == `OFS_STATUS) ||
                 (a == `OFS_PINS);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_disable_reg <= `FEAT_DIS_RESET;
    end else if (wr_en && paddr == `OFS_FEATURE_DISABLE) begin
      feature_disable_reg <= pwdata[`FEAT_W-1:0];
    end
  end

  // ****************************************************************
  // read word layouts
  // ****************************************************************
  function automatic logic [31:0] disable_word(input logic [`FEAT_W-1:0] d);
    disable_word = `WORD_ZERO;
    disable_word[`FEAT_W-1:0] = d;
  endfunction

  function automatic logic [31:0] status_word(input mode_ctrl_t c);
    status_word = `WORD_ZERO;
    status_word[`ST_MODE_LSB +: $bits(transport_mode_t)] = c.mode;
    status_word[`ST_WIDE] = c.wide_bus;
    status_word[`ST_SCRAMBLE] = c.scramble_en;
    status_word[`ST_ASI_ENC] = c.asi_encode_en;
    status_word[`ST_FEAT_LSB +: `FEAT_W] = c.feature_en;
  endfunction

  function automatic logic [31:0] pins_word(input ctrl_pins_t p);
    pins_word = `WORD_ZERO;
    pins_word[`PIN_TRANSPORT] = p.transport_mode_pin;
    pins_word[`PIN_VIDEO] = p.video_path_enable_pin;
    pins_word[`PIN_WIDTH] = p.bus_width_select;
    pins_word[`PIN_MASTER] = p.processing_master_enable;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `WORD_ZERO;
    end else if (rd_en) begin
      unique case (paddr)
        `OFS_FEATURE_DISABLE: prdata_reg <= disable_word(feature_disable_reg);
        `OFS_STATUS: prdata_reg <= status_word(ctrl_reg);
        `OFS_PINS: prdata_reg <= pins_word(pins_sync);
        default: prdata_reg <= `WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_reg <= !addr_known(paddr);
    end else if (!psel) begin
      pslverr_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // mode checks
  // ****************************************************************
  chk_asi_mode_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pins_sync.transport_mode_pin && !pins_sync.video_path_enable_pin)
    |=> (mode_ctrl.mode == MODE_TRANSPORT && mode_ctrl.asi_encode_en))
    else $error("asi mode not selected");

  chk_no_asi_encode: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pins_sync.transport_mode_pin
    |=> !mode_ctrl.asi_encode_en)
    else $error("asi encoding with transport pin low");

  chk_video_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pins_sync.video_path_enable_pin && !pins_sync.transport_mode_pin)
    |=> (mode_ctrl.mode == MODE_VIDEO && mode_ctrl.scramble_en))
    else $error("video mode not selected");

  chk_video_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pins_sync.video_path_enable_pin
    |=> (!mode_ctrl.scramble_en && mode_ctrl.feature_en == `FEAT_NONE))
    else $error("video path active while off");

  chk_pass_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!pins_sync.video_path_enable_pin && !pins_sync.transport_mode_pin)
    |=> (mode_ctrl.mode == MODE_PASS && !mode_ctrl.asi_encode_en
         && !mode_ctrl.scramble_en))
    else $error("pass-through not selected");

  chk_conflict_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pins_sync.transport_mode_pin && pins_sync.video_path_enable_pin)
    |=> (mode_ctrl.mode == MODE_CONFLICT && !mode_ctrl.scramble_en
         && !mode_ctrl.asi_encode_en && mode_ctrl.feature_en == `FEAT_NONE))
    else $error("mode entered with both mode pins high");

  // ****************************************************************
  // width checks
  // ****************************************************************
  chk_width_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pins_sync.transport_mode_pin
    |=> (mode_ctrl.wide_bus == $past(pins_sync.bus_width_select)))
    else $error("width not taken from select");

  chk_width_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_ctrl.mode == MODE_TRANSPORT)
    |-> !mode_ctrl.wide_bus)
    else $error("width used in asi mode");

  chk_width_pin_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($rose(pins.bus_width_select) && !pins.transport_mode_pin)
    ##1 (pins.bus_width_select && !pins.transport_mode_pin) [*3]
    |-> ##1 mode_ctrl.wide_bus)
    else $error("wide bus not reached after sync");

  // ****************************************************************
  // feature checks
  // ****************************************************************
  chk_all_features: assert property (
    @(posedge pclk) disable iff (!presetn)
    (decode_mode(pins_sync) == MODE_VIDEO && pins_sync.processing_master_enable
     && feature_disable_reg == `FEAT_NONE)
    |=> (mode_ctrl.feature_en == `FEAT_ALL))
    else $error("features not all enabled");

  chk_feature_subset: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((mode_ctrl.feature_en & $past(feature_disable_reg)) == `FEAT_NONE))
    else $error("disabled feature active");

  chk_feature_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
    (decode_mode(pins_sync) == MODE_VIDEO && pins_sync.processing_master_enable)
    |=> (mode_ctrl.feature_en == (`FEAT_ALL & ~$past(feature_disable_reg))))
    else $error("enabled feature suppressed");

  chk_master_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pins_sync.processing_master_enable
    |=> (mode_ctrl.feature_en == `FEAT_NONE))
    else $error("feature on with master low");

  // ****************************************************************
  // sync checks
  // ****************************************************************
  chk_sync_latency: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(pins)
    |-> ##3 (mode_ctrl.mode == decode_mode($past(pins, 3))))
    else $error("pin change not decoded three edges later");

  chk_sync_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(pins)
    |-> ##2 (mode_ctrl.mode == decode_mode($past(pins, 3))))
    else $error("pin change decoded before synchronisation");

  // ****************************************************************
  // bus checks
  // ****************************************************************
  chk_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !addr_known(paddr))
    |=> pslverr)
    else $error("unmapped access without error");

  chk_error_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    !psel
    |=> !pslverr)
    else $error("error response left standing");

  chk_disable_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `OFS_FEATURE_DISABLE)
    |=> (feature_disable_reg == $past(pwdata[`FEAT_W-1:0])))
    else $error("disable bits not written");

  chk_disable_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == `OFS_FEATURE_DISABLE)
    |=> $stable(feature_disable_reg))
    else $error("disable bits changed without a write");

  chk_read_status: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `OFS_STATUS)
    |=> (prdata == status_word($past(ctrl_reg))))
    else $error("status read does not match mode");

  chk_read_pins: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `OFS_PINS)
    |=> (prdata == pins_word($past(pins_sync))))
    else $error("pin read does not match synchronised pins");
endmodule

// ---- tb/pin_strap_model.sv ----
/*
 * strap model: drives the control pins as board logic would.
 * assumes the bench hands it the wanted levels on pclk edges.
 */
`timescale 1ns/10ps
module pin_strap_model (
  input wire logic pclk,
  input mode_select_pkg::ctrl_pins_t req,
  output mode_select_pkg::ctrl_pins_t pins
);
  import mode_select_pkg::*;
  ctrl_pins_t pins_reg = '0;
  // host keeps master high when it wants a feature subset
  always @(posedge pclk) begin
    pins_reg <= req;
  end
  assign pins = pins_reg;
endmodule

// ---- tb/serializer_mode_select_test.sv ----
/*
 * self-checking bench for the mode select block: apb master, pin sweep,
 * random feature disables, unmapped access and mid-run reset.
 * assumes the design and its package are compiled first.
 */
`timescale 1ns/10ps
`include "mode_select_consts.svh"
module serializer_mode_select_test;
  import mode_select_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ctrl_pins_t req = '0;
  ctrl_pins_t pins;
  mode_ctrl_t mode_ctrl;
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 32'hf8cf;
  logic [31:0] rd;
  logic [31:0] wd;
  logic err;
  logic [4:0] dis = 5'h00;
  logic [15:0] seen_wide;
  ctrl_pins_t p;
  serializer_mode_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .mode_ctrl(mode_ctrl));
  pin_strap_model strap_u (.pclk(pclk), .req(req), .pins(pins));
  initial begin
    forever #5 pclk = ~pclk;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic mode_ctrl_t exp_ctrl(input ctrl_pins_t q, input logic [4:0] d);
    mode_ctrl_t e;
    e.mode = q.transport_mode_pin ? (q.video_path_enable_pin ? MODE_CONFLICT : MODE_TRANSPORT)
      : (q.video_path_enable_pin ? MODE_VIDEO : MODE_PASS);
    e.wide_bus = q.bus_width_select && (e.mode != MODE_TRANSPORT);
    e.scramble_en = (e.mode == MODE_VIDEO);
    e.asi_encode_en = (e.mode == MODE_TRANSPORT);
    e.feature_en = (e.scramble_en && q.processing_master_enable) ? ~d : `FEAT_NONE;
    return e;
  endfunction
  function automatic logic [31:0] status_of(input mode_ctrl_t c);
    status_of = `WORD_ZERO;
    status_of[`ST_MODE_LSB +: 2] = c.mode;
    status_of[`ST_WIDE] = c.wide_bus;
    status_of[`ST_SCRAMBLE] = c.scramble_en;
    status_of[`ST_ASI_ENC] = c.asi_encode_en;
    status_of[`ST_FEAT_LSB +: `FEAT_W] = c.feature_en;
  endfunction
  task set_pins(input ctrl_pins_t q);
    mode_ctrl_t old;
    mode_ctrl_t e;
    repeat (2) @(posedge pclk);
    #1;
    old = mode_ctrl;
    @(posedge pclk);
    req <= q;
    repeat (3) @(posedge pclk);
    #1;
    check("sync_hold", {22'h00_0000, mode_ctrl}, {22'h00_0000, old});
    @(posedge pclk);
    #1;
    e = exp_ctrl(q, dis);
    check("mode_ctrl", {22'h00_0000, mode_ctrl}, {22'h00_0000, e});
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("reset_ctrl", {22'h00_0000, mode_ctrl}, `WORD_ZERO);
    apb(1'b0, `OFS_FEATURE_DISABLE, `WORD_ZERO);
    check("dis_reset", rd, `WORD_ZERO);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      p = ctrl_pins_t'(i[3:0]);
      set_pins(p);
      seen_wide[i] = mode_ctrl.wide_bus;
      if (i == 10 || i == 11) begin
        check("asi_width", {31'h0000_0000, seen_wide[i]}, {31'h0000_0000, seen_wide[i-2]});
      end
      apb(1'b0, `OFS_PINS, `WORD_ZERO);
      check("pins_reg", rd, {28'h000_0000, p[0], p[1], p[2], p[3]});
      apb(1'b0, `OFS_STATUS, `WORD_ZERO);
      check("status_reg", rd, status_of(exp_ctrl(p, dis)));
    end
    $display("test pin sweep done");
    for (int k = 0; k < 24; k++) begin
      p = ctrl_pins_t'(4'($random(seed)));
      wd = $random(seed);
      if (k == 0) wd[4:0] = `FEAT_ALL;
      if (k == 1) wd[4:0] = `FEAT_NONE;
      if (k[0]) p = {1'b0, 1'b1, p.bus_width_select, 1'b1};
      dis = wd[4:0];
      apb(1'b1, `OFS_FEATURE_DISABLE, wd);
      apb(1'b0, `OFS_FEATURE_DISABLE, `WORD_ZERO);
      check("dis_rw", {err, rd[30:0]}, {27'h000_0000, dis});
      set_pins(p);
    end
    $display("test feature subsets done");
    apb(1'b1, 12'h100, 32'hffff_ffff);
    check("unmap_werr", {31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b0, 12'h100, `WORD_ZERO);
    check("unmap_read", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, `OFS_FEATURE_DISABLE, `WORD_ZERO);
    check("unmap_keep", rd, {27'h000_0000, dis});
    $display("test unmapped done");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    check("mid_reset", {22'h00_0000, mode_ctrl}, `WORD_ZERO);
    @(posedge pclk);
    presetn <= 1'b1;
    dis = `FEAT_DIS_RESET;
    apb(1'b0, `OFS_FEATURE_DISABLE, `WORD_ZERO);
    check("dis_rearm", rd, `WORD_ZERO);
    set_pins(ctrl_pins_t'(4'h5));
    $display("test mid reset done");
    complete_run();
  end
endmodule
